// ### cmo_pkg.sv
// Overview of operation
// R1: single transfer on a standard object clears only that object's valid bit
// R2: a transmit FIFO slave's current pointer names its FIFO base object
// R3: base single transfer invalidates the FIFO only when current reaches select limit
// R4: overflow event after each FIFO send when enabled and current equals select
// R5: pending messages go out in transmit filtering priority order
// R6: a bus error delays but keeps order; the failed frame is retried first
// R7: list object error: frame acknowledged but stored in no object
// R8: list object error in transmission: finish it, then refilter
// R9: software reallocates lists only with node init set, or keeps first element
// R10: single transfer clears valid after any received data or remote frame
// R11: a remote answer of an invalidated object is never sent or retried
// R12: node frame mode 10 selects bit timing measurement into the frame counter
// R13: select 001 captures recessive edge minus last dominant edge time
// R14: select 010 and 011 capture transmit-to-echo delay, dominant and recessive
// R15: select 100 captures qualified dominant edge minus last sample point
// R16: clearing one valid bit never disturbs another object
// R17: storing a frame updates new data, lost, pending flags and receive event
// R18: transmit copy loads the node buffer and clears new data
// R19: a cancelled winner still lets other pending objects be filtered and sent
// R20: writing one to transmit request or either enable retriggers filtering
// R21: software toggles enable bits rather than valid during operation
// R22: gateway or FIFO slave with single transfer clears valid after store or send
// R23: receive update bit is set during storage and cleared afterwards
// R24: one clock domain; reset returns every pointer and flag to zero except rx_sync, rx_lvl and tx_last, set to one
package cmo_pkg;
  localparam int NOBJ  = 8;
  localparam int IW    = 3;
  localparam int CTL_W = 9;
  localparam int CNT_W = 16;
  // register pages and node offsets
  localparam logic [3:0] PG_NODE  = 4'h0;
  localparam logic [3:0] PG_CTL   = 4'h1;
  localparam logic [3:0] PG_CFG   = 4'h2;
  localparam logic [3:0] PG_DAT   = 4'h3;
  localparam logic [7:0] ADR_NODE = 8'h00;
  localparam logic [7:0] ADR_CFC  = 8'h04;
  // node control fields
  localparam int N_INIT = 0;
  localparam int N_FM   = 4;
  localparam int N_TS   = 8;
  localparam int N_LOE  = 12;
  // object control bit positions
  localparam int B_VALID = 0;
  localparam int B_TRANSMIT_REQUEST  = 1;
  localparam int B_TXA   = 2;
  localparam int B_TXB   = 3;
  localparam int B_RECEIVE_ENABLE  = 4;
  localparam int B_NEWD  = 5;
  localparam int B_LOST  = 6;
  localparam int B_RXP   = 7;
  localparam int B_RXU   = 8;
  localparam int CLR_SH  = 16;
  localparam logic [CTL_W-1:0] SET_MASK = 9'h01f;
  localparam logic [CTL_W-1:0] CLR_MASK = 9'h0ff;
  localparam logic [CTL_W-1:0] RETRIG   = 9'h00f;
  // object config fields
  localparam int F_KIND  = 0;
  localparam int F_SDT   = 2;
  localparam int F_OVIE  = 3;
  localparam int F_REMOTE_ANSWER_REDIRECT = 4;
  localparam int F_CUR   = 8;
  localparam int F_SEL   = 12;
  // frame mode and timing selections
  localparam logic [1:0] FM_TIMING = 2'h2;
  localparam logic [2:0] TS_REC    = 3'h1;
  localparam logic [2:0] TS_TXDOM  = 3'h2;
  localparam logic [2:0] TS_TXREC  = 3'h3;
  localparam logic [2:0] TS_SYNC   = 3'h4;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [2:0]       RXD_IDLE = 3'h7;

  typedef enum logic [1:0] {K_STD, K_TXBASE, K_TXSLV, K_GWDST} cmo_kind_type;
  typedef enum logic [1:0] {T_IDLE, T_FILT, T_COPY, T_BUSY} cmo_tx_type;

  typedef struct packed {
    cmo_kind_type    kind;
    logic            single_transfer_mode;
    logic            ovie;
    logic            remote_answer_redirect;
    logic [IW-1:0]   cur;
    logic [IW-1:0]   sel;
  } cmo_cfg_type;

  typedef struct packed {
    cmo_tx_type                   tx;
    logic [IW-1:0]                win;
    logic                         filt_req;
    logic [NOBJ-1:0][CTL_W-1:0]   ctl;
    cmo_cfg_type [NOBJ-1:0]       cfg;
    logic [NOBJ-1:0][31:0]        data;
    logic [31:0]                  tx_buf;
    logic                         init;
    logic [1:0]                   fmode;
    logic [2:0]                   tsel;
    logic                         loe;
    logic [CNT_W-1:0]             cfc;
    logic [CNT_W-1:0]             cnt_dom;
    logic [CNT_W-1:0]             cnt_tx;
    logic [CNT_W-1:0]             cnt_sp;
    logic [2:0]                   rx_sync;
    logic                         rx_lvl;
    logic                         tx_last;
    logic                         rx_stage;
    logic                         rx_remote;
    logic [IW-1:0]                rx_obj;
    logic [31:0]                  rx_data;
    logic                         tx_start;
    logic                         rx_irq;
    logic [IW-1:0]                irq_obj;
    logic                         ovf;
    logic [IW-1:0]                ovf_b;
    logic [31:0]                  prdata;
    logic                         pslverr;
  } cmo_state_type;
endpackage : cmo_pkg

// ### cmo_handler.sv
`timescale 1ns/10ps
module cmo_handler (
  // clock and reset
  input  wire logic                      clk_sys_i,
  input  wire logic                      sys_rst_i,
  // apb slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [11:0]               paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // can node events
  input  wire logic                      rx_done_i,
  input  wire logic [cmo_pkg::IW-1:0]    rx_obj_i,
  input  wire logic                      rx_remote_i,
  input  wire logic [31:0]               rx_data_i,
  input  wire logic                      loe_i,
  input  wire logic                      tx_done_i,
  input  wire logic                      tx_err_i,
  // bit timing sources
  input  wire logic                      rxd_i,
  input  wire logic                      txd_i,
  input  wire logic                      sample_point_i,
  input  wire logic                      sync_qual_i,
  // node outputs
  output logic                           tx_start_o,
  output logic      [cmo_pkg::IW-1:0]    tx_obj_o,
  output logic      [31:0]               tx_buf_o,
  output logic                           rx_irq_o,
  output logic      [cmo_pkg::IW-1:0]    rx_irq_obj_o,
  output logic                           ovf_irq_o,
  output logic                           node_init_o
);

  cmo_pkg::cmo_state_type st;
  cmo_pkg::cmo_state_type next_st;

  // object may compete in transmit filtering
  function automatic logic cand(input logic [cmo_pkg::CTL_W-1:0] c);
    return c[cmo_pkg::B_VALID] & c[cmo_pkg::B_TRANSMIT_REQUEST] & c[cmo_pkg::B_TXA] & c[cmo_pkg::B_TXB];
  endfunction : cand

  // lowest index wins; msb flags a winner
  function automatic logic [cmo_pkg::IW:0] pick(
    input logic [cmo_pkg::NOBJ-1:0][cmo_pkg::CTL_W-1:0] c);
    logic [cmo_pkg::IW:0] r;
    r = '0;
    for (int i = cmo_pkg::NOBJ - 1; i >= 0; i--) begin
      if (cand(c[i])) begin
        r = {1'b1, cmo_pkg::IW'(i)};
      end
    end
    return r;
  endfunction : pick

  // saturating cycle counter step
  function automatic logic [cmo_pkg::CNT_W-1:0] sat(input logic [cmo_pkg::CNT_W-1:0] v);
    return (&v) ? v : cmo_pkg::CNT_W'(v + 1'b1);
  endfunction : sat

  // next state
  always_comb begin
    logic                        rx_edge;
    logic                        rx_rise;
    logic                        rx_fall;
    logic                        tx_edge;
    logic [3:0]                  pg;
    logic [cmo_pkg::IW-1:0]      ix;
    logic [cmo_pkg::IW-1:0]      b;
    logic [cmo_pkg::IW-1:0]      nc;
    logic [cmo_pkg::IW-1:0]      o;
    logic [cmo_pkg::IW-1:0]      t;
    logic [cmo_pkg::IW:0]        pk;
    logic [cmo_pkg::CTL_W-1:0]   clr;
    logic [cmo_pkg::CTL_W-1:0]   sw_set;
    logic [31:0]                 rd;
    logic                        hit;
    logic                        wr;
    logic                        retrig;
    cmo_pkg::cmo_cfg_type        c;
    rx_edge = 1'b0;
    rx_rise = 1'b0;
    rx_fall = 1'b0;
    tx_edge = 1'b0;
    pg      = paddr_i[11:8];
    ix      = paddr_i[cmo_pkg::IW+1:2];
    b       = '0;
    nc      = '0;
    o       = '0;
    t       = '0;
    pk      = '0;
    clr     = '0;
    sw_set  = '0;
    rd      = '0;
    hit     = 1'b0;
    wr      = 1'b0;
    retrig  = 1'b0;
    c       = '0;
    next_st = st;
    next_st.tx_start = 1'b0;
    next_st.rx_irq   = 1'b0;
    next_st.ovf      = 1'b0;

    // receive pin synchroniser and edge detect
    next_st.rx_sync = {st.rx_sync[1:0], rxd_i};
    rx_edge = (st.rx_sync[1] == st.rx_sync[2]) && (st.rx_sync[2] != st.rx_lvl);
    rx_rise = rx_edge & st.rx_sync[2];
    rx_fall = rx_edge & ~st.rx_sync[2];
    if (rx_edge) begin
      next_st.rx_lvl = st.rx_sync[2];
    end
    tx_edge = txd_i != st.tx_last;
    next_st.tx_last = txd_i;

    // edge and sample point interval counters
    next_st.cnt_dom = rx_fall ? cmo_pkg::CNT_RST : sat(st.cnt_dom);
    next_st.cnt_tx  = tx_edge ? cmo_pkg::CNT_RST : sat(st.cnt_tx);
    next_st.cnt_sp  = sample_point_i ? cmo_pkg::CNT_RST : sat(st.cnt_sp);

    // timing capture into frame counter, current cycle included
    if (st.fmode == cmo_pkg::FM_TIMING) begin // R12
      case (st.tsel)
        cmo_pkg::TS_REC: begin
          if (rx_rise) next_st.cfc = sat(st.cnt_dom); // R13
        end
        cmo_pkg::TS_TXDOM: begin
          if (rx_fall) next_st.cfc = sat(st.cnt_tx); // R14
        end
        cmo_pkg::TS_TXREC: begin
          if (rx_rise) next_st.cfc = sat(st.cnt_tx); // R14
        end
        cmo_pkg::TS_SYNC: begin
          if (rx_fall && sync_qual_i) next_st.cfc = sat(st.cnt_sp); // R15
        end
        default: begin
        end
      endcase
    end

    // apb address decode and read mux
    case (pg)
      cmo_pkg::PG_NODE: begin
        hit = (paddr_i[7:0] == cmo_pkg::ADR_NODE) || (paddr_i[7:0] == cmo_pkg::ADR_CFC);
        if (paddr_i[7:0] == cmo_pkg::ADR_CFC) begin
          rd[cmo_pkg::CNT_W-1:0] = st.cfc;
        end else begin
          rd[cmo_pkg::N_INIT]     = st.init;
          rd[cmo_pkg::N_FM +: 2]  = st.fmode;
          rd[cmo_pkg::N_TS +: 3]  = st.tsel;
          rd[cmo_pkg::N_LOE]      = st.loe;
        end
      end
      cmo_pkg::PG_CTL, cmo_pkg::PG_CFG, cmo_pkg::PG_DAT: begin
        hit = paddr_i[7:cmo_pkg::IW+2] == '0;
        c   = st.cfg[ix];
        if (pg == cmo_pkg::PG_CTL) begin
          rd[cmo_pkg::CTL_W-1:0] = st.ctl[ix];
        end else if (pg == cmo_pkg::PG_CFG) begin
          rd[cmo_pkg::F_KIND +: 2]      = c.kind;
          rd[cmo_pkg::F_SDT]            = c.single_transfer_mode;
          rd[cmo_pkg::F_OVIE]           = c.ovie;
          rd[cmo_pkg::F_REMOTE_ANSWER_REDIRECT]          = c.remote_answer_redirect;
          rd[cmo_pkg::F_CUR +: cmo_pkg::IW] = c.cur;
          rd[cmo_pkg::F_SEL +: cmo_pkg::IW] = c.sel;
        end else begin
          rd = st.data[ix];
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (psel_i && !penable_i) begin
      next_st.prdata  = hit ? rd : '0;
      next_st.pslverr = !hit;
    end
    wr = psel_i && penable_i && pwrite_i && !st.pslverr;

    // software writes, clears first
    if (wr) begin
      case (pg)
        cmo_pkg::PG_NODE: begin
          if (paddr_i[7:0] == cmo_pkg::ADR_NODE) begin
            next_st.init  = pwdata_i[cmo_pkg::N_INIT];
            next_st.fmode = pwdata_i[cmo_pkg::N_FM +: 2];
            next_st.tsel  = pwdata_i[cmo_pkg::N_TS +: 3];
            if (pwdata_i[cmo_pkg::N_LOE]) next_st.loe = 1'b0;
          end
        end
        cmo_pkg::PG_CTL: begin
          clr    = pwdata_i[cmo_pkg::CLR_SH +: cmo_pkg::CTL_W] & cmo_pkg::CLR_MASK;
          sw_set = pwdata_i[cmo_pkg::CTL_W-1:0] & cmo_pkg::SET_MASK;
          next_st.ctl[ix] = st.ctl[ix] & ~clr; // R16
          retrig = |((clr | sw_set) & cmo_pkg::RETRIG); // R19 R20
        end
        cmo_pkg::PG_CFG: begin
          c.kind  = cmo_pkg::cmo_kind_type'(pwdata_i[cmo_pkg::F_KIND +: 2]);
          c.single_transfer_mode   = pwdata_i[cmo_pkg::F_SDT];
          c.ovie  = pwdata_i[cmo_pkg::F_OVIE];
          c.remote_answer_redirect = pwdata_i[cmo_pkg::F_REMOTE_ANSWER_REDIRECT];
          c.cur   = pwdata_i[cmo_pkg::F_CUR +: cmo_pkg::IW];
          c.sel   = pwdata_i[cmo_pkg::F_SEL +: cmo_pkg::IW];
          next_st.cfg[ix] = c;
        end
        default: begin
          next_st.data[ix] = pwdata_i;
        end
      endcase
    end

    // transmit filtering and sequencing
    case (st.tx)
      cmo_pkg::T_IDLE: begin
        if (st.filt_req && !st.init) begin
          next_st.filt_req = 1'b0;
          next_st.tx       = cmo_pkg::T_FILT;
        end
      end
      cmo_pkg::T_FILT: begin
        pk = pick(st.ctl); // R5
        next_st.win = pk[cmo_pkg::IW-1:0];
        next_st.tx  = pk[cmo_pkg::IW] ? cmo_pkg::T_COPY : cmo_pkg::T_IDLE;
      end
      cmo_pkg::T_COPY: begin
        if (cand(next_st.ctl[st.win])) begin // R11
          next_st.tx_buf = st.data[st.win]; // R18
          next_st.ctl[st.win][cmo_pkg::B_NEWD] = 1'b0; // R18
          next_st.tx_start = 1'b1;
          next_st.tx       = cmo_pkg::T_BUSY;
        end else begin
          next_st.filt_req = 1'b1; // R19
          next_st.tx       = cmo_pkg::T_IDLE;
        end
      end
      cmo_pkg::T_BUSY: begin
        if (tx_done_i) begin
          next_st.ctl[st.win][cmo_pkg::B_TRANSMIT_REQUEST] = 1'b0;
          c = st.cfg[st.win];
          b = (c.kind == cmo_pkg::K_TXSLV) ? c.cur : st.win; // R2
          if (c.kind == cmo_pkg::K_TXSLV || c.kind == cmo_pkg::K_TXBASE) begin
            nc = cmo_pkg::IW'(st.cfg[b].cur + 1'b1);
            next_st.cfg[b].cur = nc;
            if (nc == st.cfg[b].sel) begin
              if (st.cfg[b].ovie) begin
                next_st.ovf   = 1'b1; // R4
                next_st.ovf_b = b;
              end
              if (st.cfg[b].single_transfer_mode) next_st.ctl[b][cmo_pkg::B_VALID] = 1'b0; // R3
            end
          end
          if (c.single_transfer_mode && c.kind != cmo_pkg::K_TXBASE) begin
            next_st.ctl[st.win][cmo_pkg::B_VALID] = 1'b0; // R1 R22
          end
          next_st.filt_req = 1'b1; // R8
          next_st.tx       = cmo_pkg::T_IDLE;
        end else if (tx_err_i) begin
          if (cand(next_st.ctl[st.win])) begin
            next_st.tx = cmo_pkg::T_COPY; // R6
          end else begin
            next_st.filt_req = 1'b1; // R11
            next_st.tx       = cmo_pkg::T_IDLE;
          end
        end
      end
      default: begin
        next_st.tx = cmo_pkg::T_IDLE;
      end
    endcase

    // second storage step: flags, data, single transfer
    if (st.rx_stage) begin
      o = st.rx_obj;
      next_st.rx_stage = 1'b0;
      next_st.ctl[o][cmo_pkg::B_RXU] = 1'b0; // R23
      if (st.ctl[o][cmo_pkg::B_VALID] && st.ctl[o][cmo_pkg::B_RECEIVE_ENABLE]) begin // R16
        if (!st.rx_remote) next_st.data[o] = st.rx_data;
        next_st.ctl[o][cmo_pkg::B_LOST] = st.ctl[o][cmo_pkg::B_NEWD]; // R17
        next_st.ctl[o][cmo_pkg::B_NEWD] = 1'b1;
        next_st.ctl[o][cmo_pkg::B_RXP]  = 1'b1;
        next_st.rx_irq  = 1'b1;
        next_st.irq_obj = o;
        if (st.cfg[o].single_transfer_mode) next_st.ctl[o][cmo_pkg::B_VALID] = 1'b0; // R10 R22
        if (st.rx_remote) begin
          t = st.cfg[o].remote_answer_redirect ? st.cfg[o].cur : o;
          next_st.ctl[t][cmo_pkg::B_TRANSMIT_REQUEST] = 1'b1;
          retrig = 1'b1;
        end
      end
    end

    // first storage step, skipped on list object error
    if (rx_done_i && !st.init && !loe_i) begin // R7
      next_st.rx_stage  = 1'b1;
      next_st.rx_obj    = rx_obj_i;
      next_st.rx_remote = rx_remote_i;
      next_st.rx_data   = rx_data_i;
      next_st.ctl[rx_obj_i][cmo_pkg::B_RXU] = 1'b1; // R23
    end
    if (loe_i) next_st.loe = 1'b1;

    // software sets last so they win
    if (wr && pg == cmo_pkg::PG_CTL) begin
      next_st.ctl[ix] = next_st.ctl[ix] | sw_set;
    end
    if (retrig) next_st.filt_req = 1'b1; // R20
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin // R24
    if (sys_rst_i) begin
      st         <= '0;
      st.rx_sync <= cmo_pkg::RXD_IDLE; // pins idle recessive: no false edge after reset
      st.rx_lvl  <= cmo_pkg::RXD_IDLE[0];
      st.tx_last <= cmo_pkg::RXD_IDLE[0];
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign prdata_o     = st.prdata;
  assign pready_o     = psel_i & penable_i;
  assign pslverr_o    = psel_i & penable_i & st.pslverr;
  assign tx_start_o   = st.tx_start;
  assign tx_obj_o     = st.win;
  assign tx_buf_o     = st.tx_buf;
  assign rx_irq_o     = st.rx_irq;
  assign rx_irq_obj_o = st.irq_obj;
  assign ovf_irq_o    = st.ovf;
  assign node_init_o  = st.init;

  // any write access, kept out of the retry check
  logic wr_any;
  assign wr_any = psel_i & penable_i & pwrite_i;

  // assertions
  property p_rxu;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.rx_stage |-> st.ctl[st.rx_obj][cmo_pkg::B_RXU] ##1 !st.ctl[$past(st.rx_obj)][cmo_pkg::B_RXU];
  endproperty
  a_rxu: assert property (p_rxu) else $error("receive update not pulsed around storage"); // R23

  property p_store;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      rx_irq_o |-> $past(st.rx_stage) && st.ctl[rx_irq_obj_o][cmo_pkg::B_RXP];
  endproperty
  a_store: assert property (p_store) else $error("receive event without stored flags"); // R17

  property p_copy;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      tx_start_o |-> !st.ctl[tx_obj_o][cmo_pkg::B_NEWD] && tx_buf_o == $past(st.data[st.win]);
  endproperty
  a_copy: assert property (p_copy) else $error("transmit copy wrong"); // R18

  property p_ovf;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      ovf_irq_o |-> $past(tx_done_i) && st.cfg[st.ovf_b].cur == st.cfg[st.ovf_b].sel;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow event at wrong pointer"); // R4

  property p_cancel;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.tx == cmo_pkg::T_COPY |=> (st.tx == cmo_pkg::T_BUSY && tx_start_o) || (st.tx == cmo_pkg::T_IDLE && st.filt_req);
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancelled winner stalls filtering"); // R19

  property p_retry;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.tx == cmo_pkg::T_BUSY && tx_err_i && !tx_done_i && st.tx_start == 1'b0 && cand(st.ctl[st.win]) && !wr_any
      |=> st.tx == cmo_pkg::T_COPY ##1 tx_start_o && tx_obj_o == $past(st.win, 2);
  endproperty
  a_retry: assert property (p_retry) else $error("failed frame not retried first"); // R6

  property p_cfc;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.cfc != $past(st.cfc) |-> $past(st.fmode) == cmo_pkg::FM_TIMING;
  endproperty
  a_cfc: assert property (p_cfc) else $error("frame counter moved outside timing mode"); // R12

  property p_loe;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      rx_done_i && loe_i |=> !st.rx_stage ##1 !rx_irq_o;
  endproperty
  a_loe: assert property (p_loe) else $error("frame stored despite list object error"); // R7

endmodule : cmo_handler

// ### cmo_can_node_model.sv
`timescale 1ns/10ps
module cmo_can_node_model (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // frame request from the handler, failure and delay set by the test
  input  wire logic       tx_start_i,
  input  wire logic       fail_next_i,
  input  wire logic [3:0] delay_i,
  // bus outcome events
  output logic            tx_done_o,
  output logic            tx_err_o
);
  logic [3:0] wait_cnt;
  logic       busy;
  // frame on the bus: ends after delay, destroyed on command
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy      <= 1'b0;
      wait_cnt  <= 4'h0;
      tx_done_o <= 1'b0;
      tx_err_o  <= 1'b0;
    end else begin
      tx_done_o <= 1'b0;
      tx_err_o  <= 1'b0;
      if (tx_start_i) begin
        busy     <= 1'b1;
        wait_cnt <= delay_i;
      end else if (busy && wait_cnt == 4'h0) begin
        busy      <= 1'b0;
        tx_err_o  <= fail_next_i;
        tx_done_o <= !fail_next_i;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule : cmo_can_node_model

// ### cmo_handler_test.sv
`timescale 1ns/10ps
module cmo_handler_test;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} cmo_row_type;
  localparam cmo_row_type ROWS [6] = '{'{12'h300, 32'h12345678, 32'h12345678}, '{12'h104, 32'h11, 32'h11},
    '{12'h104, 32'h10000, 32'h10}, '{12'h104, 32'h100000, 32'h0}, '{12'h004, 32'hffff, 32'h0},
    '{12'h400, 32'h1, 32'h0}};
  logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, rx_data_i = 32'h0, prdata_o, tx_buf_o, q;
  logic [2:0]  rx_obj_i = 3'h0, tx_obj_o, rx_irq_obj_o;
  logic        rx_done_i = 1'b0, rx_remote_i = 1'b0, loe_i = 1'b0, fail = 1'b0;
  logic        rxd_i = 1'b1, txd_i = 1'b1, sample_point_i = 1'b0, sync_qual_i = 1'b0;
  logic        pready_o, pslverr_o, perr, tx_done_i, tx_err_i, tx_start_o, rx_irq_o, ovf_irq_o, node_init_o;
  logic [3:0]  dly = 4'h4;
  int          miscompares = 0, comparisons = 0, n_err = 0, n_ovf = 0;
  logic [34:0] txq[$];
  logic [2:0]  irq_q[$];

  cmo_handler i_cmo_handler (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_done_i(rx_done_i), .rx_obj_i(rx_obj_i), .rx_remote_i(rx_remote_i),
    .rx_data_i(rx_data_i), .loe_i(loe_i), .tx_done_i(tx_done_i), .tx_err_i(tx_err_i), .rxd_i(rxd_i), .txd_i(txd_i),
    .sample_point_i(sample_point_i), .sync_qual_i(sync_qual_i), .tx_start_o(tx_start_o), .tx_obj_o(tx_obj_o),
    .tx_buf_o(tx_buf_o), .rx_irq_o(rx_irq_o), .rx_irq_obj_o(rx_irq_obj_o), .ovf_irq_o(ovf_irq_o),
    .node_init_o(node_init_o));
  cmo_can_node_model i_cmo_can_node_model (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tx_start_i(tx_start_o),
    .fail_next_i(fail), .delay_i(dly), .tx_done_o(tx_done_i), .tx_err_o(tx_err_i));

  // clock
  always #5 clk_sys_i = ~clk_sys_i;
  // record node events
  always @(posedge clk_sys_i) begin
    if (tx_start_o === 1'b1) txq.push_back({tx_obj_o, tx_buf_o});
    if (rx_irq_o === 1'b1) irq_q.push_back(rx_irq_obj_o);
    if (tx_err_i === 1'b1) n_err++;
    if (ovf_irq_o === 1'b1) n_ovf++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask : chk
  // apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    cyc(1);
    penable_i <= 1'b1;
    cyc(1);
    while (pready_o !== 1'b1) cyc(1);
    q    = prdata_o;
    perr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    cyc(1);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, q);
  endtask : rd
  task automatic exp_tx(input logic [2:0] o, input logic [31:0] b);
    logic [34:0] t;
    for (int i = 0; i < 300 && txq.size() == 0; i++) cyc(1);
    if (txq.size() == 0) begin
      chk("tx started", 32'h1, 32'h0);
      return;
    end
    t = txq.pop_front();
    chk("tx object", {29'h0, o}, {29'h0, t[34:32]});
    chk("tx buffer", b, t[31:0]);
  endtask : exp_tx
  task automatic rx(input logic [2:0] o, input logic l, input logic r);
    rx_obj_i    <= o;
    rx_data_i   <= 32'hbeef;
    loe_i       <= l;
    rx_remote_i <= r;
    rx_done_i   <= 1'b1;
    cyc(1);
    rx_done_i   <= 1'b0;
    loe_i       <= 1'b0;
    rx_remote_i <= 1'b0;
    cyc(10);
  endtask : rx
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // watchdog
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    cyc(6);
    sys_rst_i <= 1'b0;
    cyc(1);
    rd(12'h000, 32'h0);
    rd(12'h100, 32'h0);
    rd(12'h004, 32'h0);
    chk("node init", 32'h0, {31'h0, node_init_o});
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, ROWS[i].e);
    end
    apb(1'b0, 12'h400, 32'h0);
    chk("slave error", 32'h1, {31'h0, perr});
    $display("end of register test");
    // order and bus error retry
    wr(12'h000, 32'h1);
    wr(12'h304, 32'ha1);
    wr(12'h308, 32'ha2);
    wr(12'h108, 32'hf);
    wr(12'h104, 32'hf);
    fail <= 1'b1;
    wr(12'h000, 32'h0);
    exp_tx(3'h1, 32'ha1);
    for (int i = 0; i < 50 && n_err == 0; i++) cyc(1);
    fail <= 1'b0;
    exp_tx(3'h1, 32'ha1);
    exp_tx(3'h2, 32'ha2);
    cyc(20);
    rd(12'h104, 32'hd);
    $display("end of order test");
    // single transfer and cancelled request
    wr(12'h000, 32'h1);
    wr(12'h20c, 32'h404);
    wr(12'h210, 32'h4);
    wr(12'h30c, 32'ha3);
    wr(12'h314, 32'ha5);
    wr(12'h10c, 32'hf);
    wr(12'h110, 32'h11);
    wr(12'h114, 32'hf);
    wr(12'h118, 32'hf);
    wr(12'h118, 32'h20000);
    dly <= 4'h0;
    wr(12'h000, 32'h0);
    exp_tx(3'h3, 32'ha3);
    exp_tx(3'h5, 32'ha5);
    cyc(20);
    rd(12'h10c, 32'hc);
    rd(12'h110, 32'h11);
    rd(12'h118, 32'hd);
    chk("tx count", 32'h0, 32'(txq.size()));
    $display("end of cancel test");
    // reception and list object error
    rx(3'h4, 1'b0, 1'b0);
    chk("irq count", 32'h1, 32'(irq_q.size()));
    chk("irq object", 32'h4, {29'h0, irq_q.pop_front()});
    rd(12'h110, 32'hb0);
    rd(12'h310, 32'hbeef);
    wr(12'h11c, 32'h11);
    rx(3'h7, 1'b1, 1'b0);
    chk("irq count", 32'h0, 32'(irq_q.size()));
    rd(12'h11c, 32'h11);
    rd(12'h000, 32'h1000);
    wr(12'h000, 32'h1000);
    rd(12'h000, 32'h0);
    wr(12'h21c, 32'h4);
    wr(12'h11c, 32'hc);
    rx(3'h7, 1'b0, 1'b1);
    chk("irq object", 32'h7, {29'h0, irq_q.pop_front()});
    chk("tx count", 32'h0, 32'(txq.size()));
    rd(12'h11c, 32'hbe);
    $display("end of receive test");
    // transmit fifo overflow
    wr(12'h000, 32'h1);
    wr(12'h200, 32'h760d);
    wr(12'h100, 32'h1);
    wr(12'h218, 32'h2);
    wr(12'h318, 32'ha6);
    wr(12'h118, 32'h2);
    wr(12'h000, 32'h0);
    exp_tx(3'h6, 32'ha6);
    cyc(20);
    chk("overflow count", 32'h1, 32'(n_ovf));
    rd(12'h100, 32'h0);
    rd(12'h200, 32'h770d);
    $display("end of fifo test");
    // bit timing measurement, all selections
    for (int s = 1; s <= 4; s++) begin
      wr(12'h000, 32'h20 | 32'(s << 8));
      if (s == 3) begin
        txd_i <= 1'b0;
        rxd_i <= 1'b0;
        cyc(8);
      end
      sync_qual_i    <= (s == 4);
      sample_point_i <= (s == 4);
      if (s == 1) rxd_i <= 1'b0;
      if (s == 2) txd_i <= 1'b0;
      if (s == 3) txd_i <= 1'b1;
      cyc(1);
      sample_point_i <= 1'b0;
      cyc(11);
      rxd_i <= (s == 1 || s == 3);
      cyc(8);
      rd(12'h004, (s == 1) ? 32'd12 : 32'd15);
      txd_i <= 1'b1;
      rxd_i <= 1'b1;
      cyc(8);
    end
    $display("end of timing test");
    print_verdict();
  end
endmodule : cmo_handler_test
